// *** bench/logic_shift_bit_branch_exec_tb_top.sv ***
// Self-checking bench for the logic/shift/bit/branch execution unit
`timescale 1ns/1ps
`default_nettype none
module logic_shift_bit_branch_exec_tb_top;
   import exec_pkg::*;
   logic core_clk, rst_n, instr_valid, instr_ready, zero_flag, carry_flag, nop_cycle;
   instr_t instr;
   logic [DATA_W-1:0] fdata, wreg;
   logic [PC_W-1:0] pc, exp_pc;
   fwrite_t fwrite;
   int n_mismatch, num_checks;
   logic_shift_bit_branch_exec DUT (.core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid),
      .instr(instr), .fdata(fdata), .instr_ready(instr_ready), .pc(pc), .wreg(wreg), .zero_flag(zero_flag),
      .carry_flag(carry_flag), .fwrite(fwrite), .nop_cycle(nop_cycle));
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // ----------------------------------------
   // Compare and drive tasks
   // ----------------------------------------
   task automatic chk_val(string nm, logic [PC_W-1:0] e, logic [PC_W-1:0] g);
      num_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk1(string nm, logic e, logic g);
      num_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("Error %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk_st(logic [7:0] w, logic z, logic c);
      chk_val("wreg", {7'h00, w}, {7'h00, wreg});
      chk1("zero_flag", z, zero_flag);
      chk1("carry_flag", c, carry_flag);
      chk_val("pc", exp_pc, pc);
   endtask
   task automatic chk_wr(logic e, logic [6:0] a, logic [7:0] d);
      chk1("fwrite_we", e, fwrite.we);
      if (e)
      begin
         chk_val("fwrite_addr", {8'h00, a}, {8'h00, fwrite.addr});
         chk_val("fwrite_data", {7'h00, d}, {7'h00, fwrite.data});
      end
   endtask
   // File address reuses the literal's low bits
   task automatic issue(op_t op, logic d, logic [2:0] b, logic [8:0] ofs, logic [7:0] k, logic [7:0] f);
      @(posedge core_clk);
      #1;
      instr_valid = 1'b1;
      instr = '{op, d, b, k[6:0], ofs, k};
      fdata = f;
      @(posedge core_clk);
      #1;
      instr_valid = 1'b0;
      exp_pc = exp_pc + PC_ONE;
   endtask
   // Offers a W-clearing AND in the flush cycle, which must be ignored
   task automatic branch(op_t op, logic [8:0] ofs);
      logic [7:0] w0;
      logic z0, c0;
      logic [PC_W-1:0] add;
      w0 = wreg;
      z0 = zero_flag;
      c0 = carry_flag;
      add = (op == REL_BRANCH_WREG_OP) ? {7'h00, wreg} : {{6{ofs[8]}}, ofs};
      @(posedge core_clk);
      #1;
      instr_valid = 1'b1;
      instr = '{op, DEST_W, 3'h0, 7'h00, ofs, 8'h00};
      fdata = 8'h00;
      @(posedge core_clk);
      #1;
      instr.op = AND_LITERAL_OP;
      exp_pc = exp_pc + PC_ONE + add;
      chk_st(w0, z0, c0);
      chk1("nop_cycle", 1'b1, nop_cycle);
      chk1("instr_ready", 1'b0, instr_ready);
      @(posedge core_clk);
      #1;
      instr_valid = 1'b0;
      chk_st(w0, z0, c0);
      chk1("nop_cycle", 1'b0, nop_cycle);
      chk1("instr_ready", 1'b1, instr_ready);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_and_lit();
      issue(ARITH_SHIFT_RIGHT_OP, DEST_W, 3'h0, 9'h0, 8'h00, 8'he7);
      chk_st(8'hf3, 1'b0, 1'b1);
      issue(AND_LITERAL_OP, DEST_F, 3'h0, 9'h0, 8'h0f, 8'h00);
      chk_st(8'h03, 1'b0, 1'b1);
      chk_wr(1'b0, 7'h0, 8'h0);
      issue(AND_LITERAL_OP, DEST_W, 3'h0, 9'h0, 8'h00, 8'hff);
      chk_st(8'h00, 1'b1, 1'b1);
   endtask
   task automatic t_and_file();
      issue(ARITH_SHIFT_RIGHT_OP, DEST_W, 3'h0, 9'h0, 8'h00, 8'h3c);
      issue(AND_FILE_OP, DEST_F, 3'h0, 9'h0, 8'h45, 8'h0f);
      chk_st(8'h1e, 1'b0, 1'b0);
      chk_wr(1'b1, 7'h45, 8'h0e);
      issue(AND_FILE_OP, DEST_W, 3'h0, 9'h0, 8'h12, 8'he1);
      chk_st(8'h00, 1'b1, 1'b0);
      chk_wr(1'b0, 7'h0, 8'h0);
   endtask
   task automatic t_shift();
      issue(ARITH_SHIFT_RIGHT_OP, DEST_F, 3'h0, 9'h0, 8'h33, 8'h81);
      chk_st(8'h00, 1'b0, 1'b1);
      chk_wr(1'b1, 7'h33, 8'hc0);
      issue(ARITH_SHIFT_RIGHT_OP, DEST_W, 3'h0, 9'h0, 8'h00, 8'h7e);
      chk_st(8'h3f, 1'b0, 1'b0);
      chk_wr(1'b0, 7'h0, 8'h0);
      issue(ARITH_SHIFT_RIGHT_OP, DEST_W, 3'h0, 9'h0, 8'h00, 8'h01);
      chk_st(8'h00, 1'b1, 1'b1);
   endtask
   task automatic t_bits();
      for (int b = 0; b < 8; b++)
      begin
         issue(BIT_CLEAR_OP, DEST_F, 3'(b), 9'h0, 8'h20, 8'hff);
         chk_wr(1'b1, 7'h20, 8'hff ^ (8'h01 << b));
         chk_st(8'h00, 1'b1, 1'b1);
         issue(BIT_SET_OP, DEST_F, 3'(b), 9'h0, 8'h21, 8'h00);
         chk_wr(1'b1, 7'h21, 8'h01 << b);
         chk_st(8'h00, 1'b1, 1'b1);
      end
   endtask
   task automatic t_branch();
      issue(ARITH_SHIFT_RIGHT_OP, DEST_W, 3'h0, 9'h0, 8'h00, 8'hfc);
      branch(REL_BRANCH_LITERAL_OP, 9'h1ff);
      branch(REL_BRANCH_LITERAL_OP, 9'h100);
      branch(REL_BRANCH_LITERAL_OP, 9'h0ff);
      branch(REL_BRANCH_WREG_OP, 9'h000);
   endtask
   // Reset lands in a flush cycle; a plain op must follow at once
   task automatic t_reset();
      @(posedge core_clk);
      #1;
      instr_valid = 1'b1;
      instr = '{REL_BRANCH_LITERAL_OP, DEST_W, 3'h0, 7'h00, 9'h005, 8'h00};
      @(posedge core_clk);
      #1;
      chk1("nop_cycle", 1'b1, nop_cycle);
      rst_n = 1'b0;
      #1;
      exp_pc = PC_RST;
      chk_st(W_RST, 1'b0, 1'b0);
      chk1("instr_ready", 1'b1, instr_ready);
      chk1("nop_cycle", 1'b0, nop_cycle);
      chk_wr(1'b0, 7'h0, 8'h0);
      @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      instr.op = OP_NONE;
      @(posedge core_clk);
      #1;
      instr_valid = 1'b0;
      exp_pc = PC_ONE;
      chk_st(W_RST, 1'b0, 1'b0);
      chk_wr(1'b0, 7'h0, 8'h0);
   endtask
   task automatic complete_run();
      $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      #(50 * 2000);
      n_mismatch++;
      complete_run();
   end
   initial
   begin
      rst_n = 1'b0;
      instr_valid = 1'b0;
      instr = '0;
      fdata = 8'h00;
      exp_pc = PC_RST;
      repeat (4) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      chk_st(W_RST, 1'b0, 1'b0);
      t_and_lit();
      t_and_file();
      t_shift();
      t_bits();
      t_branch();
      t_reset();
      complete_run();
   end
endmodule
`default_nettype wire

// *** hdl/exec_pkg.sv ***
// Package for the logic/shift/bit/branch execution unit
package exec_pkg;
   localparam int DATA_W = 8;
   localparam int PC_W = 15;
   localparam int FADDR_W = 7;
   localparam int OFS_W = 9;
   localparam logic [PC_W-1:0] PC_RST = 15'h0000;
   localparam logic [DATA_W-1:0] W_RST = 8'h00;
   localparam logic [PC_W-1:0] PC_ONE = 15'h0001;
   localparam int MSB = 7;
   localparam int LSB = 0;
   localparam logic DEST_W = 1'b0;
   localparam logic DEST_F = 1'b1;

   typedef enum logic [2:0]
   {
      OP_NONE = 3'h0,
      AND_LITERAL_OP = 3'h1,
      AND_FILE_OP = 3'h2,
      ARITH_SHIFT_RIGHT_OP = 3'h3,
      BIT_CLEAR_OP = 3'h4,
      BIT_SET_OP = 3'h5,
      REL_BRANCH_LITERAL_OP = 3'h6,
      REL_BRANCH_WREG_OP = 3'h7
   } op_t;

   typedef enum logic [0:0]
   {
      ST_EXEC = 1'b0,
      ST_FLUSH = 1'b1
   } phase_t;

   // One decoded instruction as presented by the decoder
   typedef struct packed
   {
      op_t op;
      logic dest;
      logic [2:0] bit_sel;
      logic [FADDR_W-1:0] faddr;
      logic [OFS_W-1:0] offset;
      logic [DATA_W-1:0] literal;
   } instr_t;

   // File register write request
   typedef struct packed
   {
      logic we;
      logic [FADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } fwrite_t;

   typedef struct packed
   {
      phase_t phase;
      logic [PC_W-1:0] pc;
      logic [DATA_W-1:0] wreg;
      logic zero;
      logic carry;
      fwrite_t fwr;
      logic busy;
   } state_t;
endpackage

// *** hdl/logic_shift_bit_branch_exec.sv ***
// Execution unit for AND, arithmetic shift, bit clear/set and relative branch
// How it works
// - literal AND into W, only Z changes
// - file AND, dest bit picks W or file
// - shift bits 7..1 down, bit0 to carry
// - shift keeps sign bit 7
// - shift result to W or file by dest
// - bit clear zeros one bit, no flags
// - bit set forces one bit, no flags
// - PC gets PC+1 plus signed 9-bit offset
// - PC gets PC+1 plus unsigned W
// - PC change takes two cycles, second NOP
`timescale 1ns/1ps
`default_nettype none
module logic_shift_bit_branch_exec
   import exec_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic instr_valid,
   input wire exec_pkg::instr_t instr,
   input wire logic [exec_pkg::DATA_W-1:0] fdata,
   output logic instr_ready,
   output logic [exec_pkg::PC_W-1:0] pc,
   output logic [exec_pkg::DATA_W-1:0] wreg,
   output logic zero_flag,
   output logic carry_flag,
   output exec_pkg::fwrite_t fwrite,
   output logic nop_cycle
);
   import exec_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   state_t cur_ff;
   state_t nxt_cur;
   logic [DATA_W-1:0] res;
   logic [PC_W-1:0] pc_inc;

   assign pc_inc = cur_ff.pc + PC_ONE;

   always_comb
   begin
      nxt_cur = cur_ff;
      res = W_RST;
      nxt_cur.fwr.we = 1'b0;
      nxt_cur.busy = 1'b0;
      case (cur_ff.phase)
         ST_EXEC:
         begin
            if (instr_valid)
            begin
               nxt_cur.pc = pc_inc;
               case (instr.op)
                  AND_LITERAL_OP:
                  begin
                     res = cur_ff.wreg & instr.literal;
                     nxt_cur.wreg = res;
                     nxt_cur.zero = (res == W_RST);
                  end
                  AND_FILE_OP:
                  begin
                     res = cur_ff.wreg & fdata;
                     nxt_cur.zero = (res == W_RST);
                     if (instr.dest == DEST_W)
                        nxt_cur.wreg = res;
                     else
                        nxt_cur.fwr = '{we: 1'b1, addr: instr.faddr, data: res};
                  end
                  ARITH_SHIFT_RIGHT_OP:
                  begin
                     res = {fdata[MSB], fdata[MSB:LSB+1]};
                     nxt_cur.carry = fdata[LSB];
                     nxt_cur.zero = (res == W_RST);
                     if (instr.dest == DEST_W)
                        nxt_cur.wreg = res;
                     else
                        nxt_cur.fwr = '{we: 1'b1, addr: instr.faddr, data: res};
                  end
                  BIT_CLEAR_OP:
                  begin
                     res = fdata;
                     res[instr.bit_sel] = 1'b0;
                     nxt_cur.fwr = '{we: 1'b1, addr: instr.faddr, data: res};
                  end
                  BIT_SET_OP:
                  begin
                     res = fdata;
                     res[instr.bit_sel] = 1'b1;
                     nxt_cur.fwr = '{we: 1'b1, addr: instr.faddr, data: res};
                  end
                  REL_BRANCH_LITERAL_OP:
                  begin
                     nxt_cur.pc = PC_W'(pc_inc + {{(PC_W-OFS_W){instr.offset[OFS_W-1]}}, instr.offset});
                     nxt_cur.phase = ST_FLUSH;
                     nxt_cur.busy = 1'b1;
                  end
                  REL_BRANCH_WREG_OP:
                  begin
                     nxt_cur.pc = PC_W'(pc_inc + {{(PC_W-DATA_W){1'b0}}, cur_ff.wreg});
                     nxt_cur.phase = ST_FLUSH;
                     nxt_cur.busy = 1'b1;
                  end
                  default:
                  begin
                     nxt_cur.pc = pc_inc;
                  end
               endcase
            end
         end
         ST_FLUSH:
         begin
            nxt_cur.phase = ST_EXEC;
         end
         default:
         begin
            nxt_cur.phase = ST_EXEC;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cur_ff <= '{phase: ST_EXEC, pc: PC_RST, wreg: W_RST, zero: 1'b0, carry: 1'b0,
                     fwr: '{we: 1'b0, addr: '0, data: W_RST}, busy: 1'b0};
      end
      else
      begin
         cur_ff <= nxt_cur;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Decoder must hold the fetched word during the flush cycle
   assign instr_ready = (cur_ff.phase == ST_EXEC);
   // Busy is set only by a taken branch, so it marks the flush cycle
   assign nop_cycle = cur_ff.busy;
   assign pc = cur_ff.pc;
   assign wreg = cur_ff.wreg;
   assign zero_flag = cur_ff.zero;
   assign carry_flag = cur_ff.carry;
   assign fwrite = cur_ff.fwr;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   logic take;
   assign take = instr_valid && instr_ready;

   property p_and_lit;
      @(posedge core_clk) disable iff (!rst_n)
      take && instr.op == AND_LITERAL_OP |=> wreg == ($past(wreg) & $past(instr.literal))
         && carry_flag == $past(carry_flag) && !fwrite.we;
   endproperty
   a_and_lit: assert property (p_and_lit) else $error("literal AND wrong");

   property p_and_file;
      @(posedge core_clk) disable iff (!rst_n)
      take && instr.op == AND_FILE_OP && instr.dest == DEST_F |=>
         fwrite.we && fwrite.data == ($past(wreg) & $past(fdata)) && wreg == $past(wreg);
   endproperty
   a_and_file: assert property (p_and_file) else $error("file AND wrong");

   property p_shift_carry;
      @(posedge core_clk) disable iff (!rst_n)
      take && instr.op == ARITH_SHIFT_RIGHT_OP |=> carry_flag == $past(fdata[LSB]);
   endproperty
   a_shift_carry: assert property (p_shift_carry) else $error("shift carry wrong");

   property p_shift_sign;
      @(posedge core_clk) disable iff (!rst_n)
      take && instr.op == ARITH_SHIFT_RIGHT_OP && instr.dest == DEST_W |=>
         wreg[MSB] == $past(fdata[MSB]) && wreg[MSB-1:LSB] == $past(fdata[MSB:LSB+1]);
   endproperty
   a_shift_sign: assert property (p_shift_sign) else $error("shift sign lost");

   property p_shift_dest;
      @(posedge core_clk) disable iff (!rst_n)
      take && instr.op == ARITH_SHIFT_RIGHT_OP |=> fwrite.we == $past(instr.dest);
   endproperty
   a_shift_dest: assert property (p_shift_dest) else $error("shift dest wrong");

   property p_bclr;
      @(posedge core_clk) disable iff (!rst_n)
      take && instr.op == BIT_CLEAR_OP |=> fwrite.we && fwrite.addr == $past(instr.faddr)
         && fwrite.data == ($past(fdata) & ~(8'h01 << $past(instr.bit_sel)))
         && $stable(zero_flag) && $stable(carry_flag);
   endproperty
   a_bclr: assert property (p_bclr) else $error("bit clear wrong");

   property p_bset;
      @(posedge core_clk) disable iff (!rst_n)
      take && instr.op == BIT_SET_OP |=> fwrite.we && fwrite.addr == $past(instr.faddr)
         && fwrite.data == ($past(fdata) | (8'h01 << $past(instr.bit_sel)))
         && $stable(zero_flag) && $stable(carry_flag);
   endproperty
   a_bset: assert property (p_bset) else $error("bit set wrong");

   property p_bra;
      @(posedge core_clk) disable iff (!rst_n)
      take && instr.op == REL_BRANCH_LITERAL_OP |=> pc == PC_W'($past(pc) + PC_ONE
         + {{(PC_W-OFS_W){$past(instr.offset[OFS_W-1])}}, $past(instr.offset)});
   endproperty
   a_bra: assert property (p_bra) else $error("literal branch target wrong");

   property p_brw;
      @(posedge core_clk) disable iff (!rst_n)
      take && instr.op == REL_BRANCH_WREG_OP |=> pc == PC_W'($past(pc) + PC_ONE
         + {{(PC_W-DATA_W){1'b0}}, $past(wreg)});
   endproperty
   a_brw: assert property (p_brw) else $error("W branch target wrong");

   property p_two_cycle;
      @(posedge core_clk) disable iff (!rst_n)
      take && (instr.op == REL_BRANCH_LITERAL_OP || instr.op == REL_BRANCH_WREG_OP) |=>
         nop_cycle && !instr_ready ##1 instr_ready && $stable(pc) && $stable(wreg);
   endproperty
   a_two_cycle: assert property (p_two_cycle) else $error("branch not two cycles");

   property p_zero;
      @(posedge core_clk) disable iff (!rst_n)
      take && instr.op == AND_LITERAL_OP |=> zero_flag == (wreg == W_RST);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
endmodule
`default_nettype wire
